// ===== hdl/tfc_top.sv
// Multi-function terminal control logic for a motor drive
// Summary of operation
// - Fault drives fault output, shuts drive off
// - Fault clears: run removed, keypad, code 39
// - Reset request ignored while run requested
// - Code 40 raises overheat alarm, keeps running
// - Code 45 takes terminal levels from link
// - Code 46 closed disables PID
// - Code 47 closing zeroes PID integral
// - Code 48 closed freezes PID integral
// - Code 49 closed bypasses setpoint ramp
// - Code 50 selects PID input characteristic
// - Codes 53-55 add offset frequencies
// - Code 60 open blocks writes but monitor
// - Code 61 closed 100 ms samples analog
// - Power loss zeroes held reference
// - Analog hold with conflicting codes flags error
// - Code 65 brakes; run or jog releases
// - Code 69 open rejects run, shows indication
// - Enable open during run stops drive
// - Four outputs, codes 0 to 149
// - Codes 100-149 invert function code-100
// - Normally-closed inputs detect on opening
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "tfc_defs.svh"
module tfc_top #(
	parameter int HOLD_CYC = `TFC_HOLD_CYC
) (
	input  wire logic                     ref_clk,
	input  wire logic                     reset_n,
	input  wire logic [`TFC_N_IN-1:0]     term_in,
	input  wire logic [`TFC_N_IN-1:0]     comm_term_in,
	input  wire logic                     run_req,
	input  wire logic                     jog_req,
	input  wire logic                     keypad_reset,
	input  wire logic                     fault_detect,
	input  wire logic [15:0]              analog_freq_cmd,
	input  wire logic [`TFC_ADDR_W-1:0]   reg_addr,
	input  wire logic [`TFC_DATA_W-1:0]   reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [`TFC_DATA_W-1:0]   reg_rdata,
	output logic                          drive_output_en,
	output logic                          fault_active,
	output logic                          external_overheat_alarm,
	output logic                          pid_active,
	output logic                          pid_integ_clear,
	output logic                          pid_integ_hold,
	output logic                          pid_ramp_bypass,
	output logic                          pid_char_alt,
	output logic      [2:0]               offset_add_en,
	output logic      [15:0]              freq_ref,
	output logic                          hold_conflict_error,
	output logic                          dc_brake,
	output logic                          not_enabled_indication,
	output logic                          stop_req,
	output logic      [1:0]               stop_method,
	output logic      [`TFC_N_OUT-1:0]    out_term
);
	logic [`TFC_N_IN-1:0]  phys_lvl;
	logic [`TFC_N_IN-1:0]  lvl;
	tfc_pkg::tfc_code_t    in_sel_q  [`TFC_N_IN];
	tfc_pkg::tfc_code_t    out_sel_q [`TFC_N_OUT];
	logic [15:0]           ctrl_q;
	logic [`TFC_N_IN-1:0]  nc_mask_q;
	logic [15:0]           freq_mon_q;
	tfc_pkg::tfc_state_e   state_q;
	tfc_pkg::tfc_state_e   state_d;
	logic                  run_prev_q;
	logic                  rst_prev_q;
	logic                  irst_prev_q;
	logic [20:0]           hold_cnt_q;
	logic                  hold_valid_q;
	logic [15:0]           held_q;
	logic [`TFC_OUT_FUNCS-1:0] src;

	tfc_sync #(.W(`TFC_N_IN)) u_sync (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.raw     (term_in),
		.synced  (phys_lvl)
	);

	function automatic logic code_used(input tfc_pkg::tfc_code_t c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < `TFC_N_IN; i++) begin
			if (in_sel_q[i] == c) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : code_used
	function automatic logic code_on(input tfc_pkg::tfc_code_t c,
	                                 input logic [`TFC_N_IN-1:0] l);
		logic r;
		r = 1'b0;
		for (int i = 0; i < `TFC_N_IN; i++) begin
			if (in_sel_q[i] == c && l[i]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : code_on
	// Communication mode is chosen from the physical terminal itself
	logic comm_mode;
	assign comm_mode = code_on(`TFC_CODE_COMM, phys_lvl ^ nc_mask_q);
	assign lvl = (comm_mode ? comm_term_in : phys_lvl) ^ nc_mask_q;

	logic rst_on;
	logic int_rst_on;
	logic en_used;
	logic enabled;
	logic lock_used;
	logic hold_on;
	logic run_rise;
	logic fault_clear;
	assign rst_on     = code_on(`TFC_CODE_FLT_RST, lvl);
	assign int_rst_on = code_on(`TFC_CODE_INT_RST, lvl);
	assign en_used    = code_used(`TFC_CODE_ENABLE);
	assign enabled    = !en_used || code_on(`TFC_CODE_ENABLE, lvl);
	assign lock_used  = code_used(`TFC_CODE_LOCKOUT);
	assign hold_on    = code_on(`TFC_CODE_AN_HOLD, lvl);
	assign run_rise   = run_req && !run_prev_q;
	// Reset sources only count once run is withdrawn
	assign fault_clear = !run_req
		&& (run_prev_q || keypad_reset || (rst_on && !rst_prev_q));
	// Register port
	logic wr_allow;
	assign wr_allow = !lock_used || code_on(`TFC_CODE_LOCKOUT, lvl)
		|| reg_addr == `TFC_REG_FREQ_MON;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < `TFC_N_IN; i++) begin
				in_sel_q[i] <= `TFC_IN_SEL_RESET;
			end
			for (int i = 0; i < `TFC_N_OUT; i++) begin
				out_sel_q[i] <= `TFC_OUT_SEL_RESET;
			end
			ctrl_q     <= `TFC_CTRL_RESET;
			nc_mask_q  <= '0;
			freq_mon_q <= '0;
		end else if (reg_wr && wr_allow) begin
			if (reg_addr < `TFC_REG_OUT_SEL0) begin
				in_sel_q[reg_addr[2:0]] <= reg_wdata[7:0];
			end else if (reg_addr < `TFC_REG_CTRL) begin
				if (reg_wdata[7:0] <= `TFC_OUT_CODE_MAX) begin
					out_sel_q[reg_addr[1:0]] <= reg_wdata[7:0];
				end
			end else if (reg_addr == `TFC_REG_CTRL) begin
				ctrl_q <= reg_wdata;
			end else if (reg_addr == `TFC_REG_NC_MASK) begin
				nc_mask_q <= reg_wdata[`TFC_N_IN-1:0];
			end else if (reg_addr == `TFC_REG_FREQ_MON) begin
				freq_mon_q <= reg_wdata;
			end
		end
	end

	logic [15:0] status;
	assign status = {8'h00, 1'b0, hold_valid_q, comm_mode, hold_conflict_error,
		not_enabled_indication, external_overheat_alarm, state_q};

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr < `TFC_REG_OUT_SEL0) begin
				reg_rdata <= {8'h00, in_sel_q[reg_addr[2:0]]};
			end else if (reg_addr < `TFC_REG_CTRL) begin
				reg_rdata <= {8'h00, out_sel_q[reg_addr[1:0]]};
			end else if (reg_addr == `TFC_REG_CTRL) begin
				reg_rdata <= ctrl_q;
			end else if (reg_addr == `TFC_REG_NC_MASK) begin
				reg_rdata <= {8'h00, nc_mask_q};
			end else if (reg_addr == `TFC_REG_FREQ_MON) begin
				reg_rdata <= freq_mon_q;
			end else begin
				reg_rdata <= status;
			end
		end else begin
			reg_rdata <= '0;
		end
	end
	// Run and fault sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			tfc_pkg::TFC_IDLE: begin
				if (fault_detect) begin
					state_d = tfc_pkg::TFC_FAULT;
				end else if (run_rise && enabled) begin
					state_d = tfc_pkg::TFC_RUN;
				end
			end
			tfc_pkg::TFC_RUN: begin
				if (fault_detect) begin
					state_d = tfc_pkg::TFC_FAULT;
				end else if (!run_req || !enabled) begin
					state_d = tfc_pkg::TFC_IDLE;
				end
			end
			tfc_pkg::TFC_FAULT: begin
				if (fault_clear && !fault_detect) begin
					state_d = tfc_pkg::TFC_IDLE;
				end
			end
			default: state_d = tfc_pkg::TFC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= tfc_pkg::TFC_IDLE;
			run_prev_q  <= 1'b0;
			rst_prev_q  <= 1'b0;
			irst_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			run_prev_q  <= run_req;
			rst_prev_q  <= rst_on;
			irst_prev_q <= int_rst_on;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_req    <= 1'b0;
			stop_method <= '0;
		end else begin
			stop_req    <= state_q == tfc_pkg::TFC_RUN && run_req && !enabled
				&& !fault_detect;
			stop_method <= ctrl_q[`TFC_CTRL_STOP_MSB:`TFC_CTRL_STOP_LSB];
		end
	end

	assign drive_output_en = state_q == tfc_pkg::TFC_RUN;
	assign fault_active    = state_q == tfc_pkg::TFC_FAULT;
	// Function outputs from the decoded terminals
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			external_overheat_alarm <= 1'b0;
			pid_active              <= 1'b0;
			pid_integ_clear         <= 1'b0;
			pid_integ_hold          <= 1'b0;
			pid_ramp_bypass         <= 1'b0;
			pid_char_alt            <= 1'b0;
			offset_add_en           <= '0;
			hold_conflict_error     <= 1'b0;
			dc_brake                <= 1'b0;
			not_enabled_indication  <= 1'b0;
		end else begin
			external_overheat_alarm <= code_on(`TFC_CODE_OVERHEAT, lvl);
			pid_active      <= ctrl_q[`TFC_CTRL_PID_EN]
				&& !code_on(`TFC_CODE_PID_DIS, lvl);
			pid_integ_clear <= int_rst_on && !irst_prev_q;
			pid_integ_hold  <= code_on(`TFC_CODE_INT_HOLD, lvl);
			pid_ramp_bypass <= code_on(`TFC_CODE_SOFT_OFF, lvl);
			pid_char_alt    <= code_on(`TFC_CODE_PID_CHAR, lvl);
			for (int k = 0; k < 3; k++) begin
				offset_add_en[k] <= code_on(8'(`TFC_CODE_OFFSET1 + k), lvl);
			end
			hold_conflict_error <= code_used(`TFC_CODE_AN_HOLD) && (
				code_used(`TFC_CODE_RAMP_HOLD)
				|| code_used(`TFC_CODE_UPDN_LO)
				|| code_used(8'(`TFC_CODE_UPDN_LO + 1))
				|| code_used(8'(`TFC_CODE_UPDN_LO + 2))
				|| code_used(`TFC_CODE_UPDN2_HI)
				|| code_used(`TFC_CODE_OFFSET1)
				|| code_used(8'(`TFC_CODE_OFFSET1 + 1))
				|| code_used(8'(`TFC_CODE_OFFSET1 + 2)));
			dc_brake <= code_on(`TFC_CODE_DC_BRAKE, lvl) && !run_req && !jog_req;
			not_enabled_indication <= !enabled;
		end
	end
	// Analog command hold; reset stands for loss of power
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_cnt_q   <= '0;
			hold_valid_q <= 1'b0;
			held_q       <= '0;
		end else if (!hold_on) begin
			hold_cnt_q <= '0;
		end else if (hold_cnt_q == 21'(HOLD_CYC - 1)) begin
			hold_cnt_q   <= hold_cnt_q + 21'd1;
			hold_valid_q <= 1'b1;
			held_q       <= analog_freq_cmd;
		end else if (hold_cnt_q < 21'(HOLD_CYC - 1)) begin
			hold_cnt_q <= hold_cnt_q + 21'd1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			freq_ref <= '0;
		end else begin
			freq_ref <= hold_valid_q ? held_q : analog_freq_cmd;
		end
	end
	// Output terminal functions
	always_comb begin
		src = '0;
		src[`TFC_SRC_RUN]     = state_q == tfc_pkg::TFC_RUN;
		src[`TFC_SRC_READY]   = state_q != tfc_pkg::TFC_FAULT && enabled;
		src[`TFC_SRC_FAULT]   = state_q == tfc_pkg::TFC_FAULT;
		src[`TFC_SRC_COMM]    = comm_mode;
		src[`TFC_SRC_ENABLED] = enabled;
	end

	for (genvar j = 0; j < `TFC_N_OUT; j++) begin : g_out
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n) begin
				out_term[j] <= 1'b0;
			end else if (out_sel_q[j] >= `TFC_OUT_INV_BASE) begin
				out_term[j] <= !src[6'(out_sel_q[j] - `TFC_OUT_INV_BASE)];
			end else if (out_sel_q[j] < 8'(`TFC_OUT_FUNCS)) begin
				out_term[j] <= src[6'(out_sel_q[j])];
			end else begin
				out_term[j] <= 1'b0;
			end
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_fault_off: assert property (state_q == tfc_pkg::TFC_FAULT |-> !drive_output_en)
		else $error("drive output on during fault");
	chk_fault_clear: assert property (state_q == tfc_pkg::TFC_FAULT && fault_clear
		&& !fault_detect |=> state_q == tfc_pkg::TFC_IDLE)
		else $error("fault not cleared");
	chk_reset_in_run: assert property (state_q == tfc_pkg::TFC_FAULT && run_req
		&& run_prev_q |=> state_q == tfc_pkg::TFC_FAULT)
		else $error("fault reset taken while run requested");
	chk_overheat_run: assert property (state_q == tfc_pkg::TFC_RUN && run_req && enabled
		&& !fault_detect && code_on(`TFC_CODE_OVERHEAT, lvl)
		|=> external_overheat_alarm && state_q == tfc_pkg::TFC_RUN)
		else $error("overheat alarm missing or drive stopped");
	chk_dc_release: assert property (run_req || jog_req |=> !dc_brake)
		else $error("dc braking kept during run or jog");
	chk_enable_block: assert property (state_q == tfc_pkg::TFC_IDLE && !enabled
		|=> state_q != tfc_pkg::TFC_RUN)
		else $error("run accepted while not enabled");
	chk_enable_stop: assert property (state_q == tfc_pkg::TFC_RUN && !enabled
		&& !fault_detect |=> state_q == tfc_pkg::TFC_IDLE && stop_req)
		else $error("no stop on enable loss");
	chk_hold_sample: assert property (hold_on && hold_cnt_q == 21'(HOLD_CYC - 1)
		|=> hold_valid_q && held_q == $past(analog_freq_cmd) ##1 freq_ref == held_q)
		else $error("analog hold not sampled");
	chk_write_lock: assert property (reg_wr && !wr_allow |=> $stable(ctrl_q)
		&& $stable(nc_mask_q))
		else $error("write passed program lockout");
	chk_integ_clear: assert property ($rose(int_rst_on) |=> pid_integ_clear ##1
		!pid_integ_clear)
		else $error("integral clear not a single pulse");

	cov_run_start: cover property (state_q == tfc_pkg::TFC_IDLE ##1
		state_q == tfc_pkg::TFC_RUN);
	cov_fault_cycle: cover property (state_q == tfc_pkg::TFC_FAULT ##[1:20]
		state_q == tfc_pkg::TFC_IDLE);
	cov_hold_taken: cover property ($rose(hold_valid_q));
	cov_enable_stop: cover property (stop_req);
endmodule : tfc_top

// ===== hdl/tfc_defs.svh
// Offsets, field positions, reset values and timing counts of the terminal control block
`ifndef TFC_DEFS_SVH
`define TFC_DEFS_SVH

`define TFC_N_IN           8
`define TFC_N_OUT          4
`define TFC_ADDR_W         4
`define TFC_DATA_W         16

`define TFC_REG_IN_SEL0    4'h0
`define TFC_REG_OUT_SEL0   4'h8
`define TFC_REG_CTRL       4'hC
`define TFC_REG_NC_MASK    4'hD
`define TFC_REG_FREQ_MON   4'hE
`define TFC_REG_STATUS     4'hF

`define TFC_CTRL_PID_EN    0
`define TFC_CTRL_STOP_LSB  1
`define TFC_CTRL_STOP_MSB  2
`define TFC_CTRL_RESET     16'h0001

`define TFC_IN_SEL_RESET   8'hFF
`define TFC_OUT_SEL_RESET  8'h00

`define TFC_CODE_UPDN_LO   8'h0A
`define TFC_CODE_UPDN2_HI  8'h0D
`define TFC_CODE_RAMP_HOLD 8'h12
`define TFC_CODE_FLT_RST   8'h27
`define TFC_CODE_OVERHEAT  8'h28
`define TFC_CODE_COMM      8'h2D
`define TFC_CODE_PID_DIS   8'h2E
`define TFC_CODE_INT_RST   8'h2F
`define TFC_CODE_INT_HOLD  8'h30
`define TFC_CODE_SOFT_OFF  8'h31
`define TFC_CODE_PID_CHAR  8'h32
`define TFC_CODE_OFFSET1   8'h35
`define TFC_CODE_LOCKOUT   8'h3C
`define TFC_CODE_AN_HOLD   8'h3D
`define TFC_CODE_DC_BRAKE  8'h41
`define TFC_CODE_ENABLE    8'h45

`define TFC_OUT_FUNCS      50
`define TFC_OUT_INV_BASE   8'h64
`define TFC_OUT_CODE_MAX   8'h95
`define TFC_SRC_RUN        0
`define TFC_SRC_READY      4
`define TFC_SRC_FAULT      11
`define TFC_SRC_COMM       12
`define TFC_SRC_ENABLED    36

`define TFC_CLK_PERIOD_NS  50
`define TFC_HOLD_TIME_MS   100
`define TFC_HOLD_CYC       ((`TFC_HOLD_TIME_MS * 1000000) / `TFC_CLK_PERIOD_NS)

`endif

// ===== hdl/tfc_pkg.sv
// Types shared by the terminal control block
package tfc_pkg;
	typedef enum logic [1:0] {
		TFC_IDLE  = 2'b00,
		TFC_RUN   = 2'b01,
		TFC_FAULT = 2'b11
	} tfc_state_e;

	typedef logic [7:0] tfc_code_t;
endpackage : tfc_pkg

// ===== hdl/tfc_sync.sv
// Two-stage synchroniser for the input terminals
`timescale 1ns/1ps
module tfc_sync #(
	parameter int W = 8
) (
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] synced
);
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n) begin
				meta_q <= 1'b0;
				sync_q <= 1'b0;
			end else begin
				meta_q <= raw[i];
				sync_q <= meta_q;
			end
		end
		assign synced[i] = sync_q;
	end
endmodule : tfc_sync

// ===== verification/tfc_switch_model.sv
// Model of the external switches and run controller facing the terminals
`timescale 1ns/1ps
module tfc_switch_model #(
	parameter int EN_BIT = 1
) (
	input  wire logic       ref_clk,
	input  wire logic [7:0] sw_cmd,
	input  wire logic       run_cmd,
	output logic      [7:0] term_in,
	output logic            run_req
);
	logic [2:0] gap_q = 3'd0;

	// Contacts settle one edge after the command
	always @(posedge ref_clk) begin
		term_in <= sw_cmd;
		if (sw_cmd[EN_BIT] && !term_in[EN_BIT] && run_req) begin
			gap_q   <= 3'd6;
			run_req <= 1'b0;
		end else if (gap_q != 3'd0) begin
			gap_q   <= gap_q - 3'd1;
			run_req <= (gap_q == 3'd1) ? run_cmd : 1'b0;
		end else begin
			run_req <= run_cmd;
		end
	end
endmodule : tfc_switch_model

// ===== verification/tb_top.sv
// Self-checking testbench of the terminal control block
`timescale 1ns/1ps
`include "tfc_defs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	logic        ref_clk, reset_n, jog_req, keypad_reset, fault_detect, reg_wr, reg_rd, run_cmd;
	logic [7:0]  term_in, comm_term_in, sw_cmd;
	logic [15:0] analog_freq_cmd, reg_wdata, reg_rdata, freq_ref, rd_d;
	logic [3:0]  reg_addr, out_term;
	logic        run_req, drive_output_en, fault_active, external_overheat_alarm, pid_active;
	logic        pid_integ_clear, pid_integ_hold, pid_ramp_bypass, pid_char_alt;
	logic        hold_conflict_error, dc_brake, not_enabled_indication, stop_req;
	logic [2:0]  offset_add_en;
	logic [1:0]  stop_method;
	int          num_errors, n_tests, cnt;
	tfc_pkg::tfc_code_t codes[4];

	tfc_top #(.HOLD_CYC(20)) u_dut (.ref_clk, .reset_n, .term_in, .comm_term_in, .run_req,
		.jog_req, .keypad_reset, .fault_detect, .analog_freq_cmd, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .drive_output_en, .fault_active,
		.external_overheat_alarm, .pid_active, .pid_integ_clear, .pid_integ_hold,
		.pid_ramp_bypass, .pid_char_alt, .offset_add_en, .freq_ref, .hold_conflict_error,
		.dc_brake, .not_enabled_indication, .stop_req, .stop_method, .out_term);
	tfc_switch_model #(.EN_BIT(1)) u_sw (.ref_clk, .sw_cmd, .run_cmd, .term_in, .run_req);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 rd_d = reg_rdata;
	endtask : rd

	task automatic sw(input logic [7:0] v);
		@(posedge ref_clk);
		sw_cmd <= v;
		settle(6);
	endtask : sw

	task automatic pulse_fault();
		@(posedge ref_clk);
		fault_detect <= 1'b1;
		@(posedge ref_clk);
		fault_detect <= 1'b0;
		settle(4);
	endtask : pulse_fault

	task automatic key_pulse();
		@(posedge ref_clk);
		keypad_reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		keypad_reset <= 1'b0;
		settle(2);
	endtask : key_pulse

	task automatic do_reset();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		sw_cmd  <= 8'h00;
		run_cmd <= 1'b0;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		settle(2);
	endtask : do_reset

	task automatic t_regs();
		do_reset();
		rd(`TFC_REG_CTRL);
		`CHK(rd_d, 16'h0001)
		rd(`TFC_REG_IN_SEL0);
		`CHK(rd_d, 16'h00FF)
		wr(`TFC_REG_OUT_SEL0 + 4'h2, 16'h0096);
		rd(`TFC_REG_OUT_SEL0 + 4'h2);
		`CHK(rd_d, 16'h0000)
		wr(`TFC_REG_OUT_SEL0 + 4'h2, 16'h0095);
		rd(`TFC_REG_OUT_SEL0 + 4'h2);
		`CHK(rd_d, 16'h0095)
		$display("test regs done");
	endtask : t_regs

	task automatic t_overheat();
		do_reset();
		wr(`TFC_REG_IN_SEL0, 16'h0028);
		run_cmd <= 1'b1;
		sw(8'h01);
		`CHK(external_overheat_alarm, 1'b1)
		`CHK(drive_output_en, 1'b1)
		rd(`TFC_REG_STATUS);
		`CHK(rd_d[2:0], 3'b101)
		wr(`TFC_REG_NC_MASK, 16'h0001);
		sw(8'h00);
		`CHK(external_overheat_alarm, 1'b1)
		sw(8'h01);
		`CHK(external_overheat_alarm, 1'b0)
		$display("test overheat done");
	endtask : t_overheat

	task automatic t_fault();
		do_reset();
		wr(`TFC_REG_OUT_SEL0, 16'h000B);
		wr(`TFC_REG_OUT_SEL0 + 4'h1, 16'h006F);
		wr(`TFC_REG_IN_SEL0 + 4'h3, 16'h0027);
		run_cmd <= 1'b1;
		settle(4);
		`CHK(out_term[1:0], 2'b10)
		pulse_fault();
		`CHK(fault_active, 1'b1)
		`CHK(drive_output_en, 1'b0)
		`CHK(out_term[1:0], 2'b01)
		key_pulse();
		sw(8'h08);
		`CHK(fault_active, 1'b1)
		sw(8'h00);
		@(posedge ref_clk);
		run_cmd <= 1'b0;
		settle(4);
		`CHK(fault_active, 1'b0)
		pulse_fault();
		key_pulse();
		`CHK(fault_active, 1'b0)
		pulse_fault();
		sw(8'h08);
		`CHK(fault_active, 1'b0)
		$display("test fault done");
	endtask : t_fault

	task automatic t_enable();
		do_reset();
		wr(`TFC_REG_IN_SEL0 + 4'h1, 16'h0045);
		wr(`TFC_REG_CTRL, 16'h0005);
		wr(`TFC_REG_OUT_SEL0 + 4'h2, 16'h0004);
		wr(`TFC_REG_OUT_SEL0 + 4'h3, 16'h0024);
		run_cmd <= 1'b1;
		settle(6);
		`CHK(not_enabled_indication, 1'b1)
		`CHK(drive_output_en, 1'b0)
		`CHK(out_term[3:2], 2'b00)
		sw(8'h02);
		settle(6);
		`CHK(drive_output_en, 1'b1)
		`CHK(out_term[3:2], 2'b11)
		`CHK(stop_method, 2'b10)
		@(posedge ref_clk);
		sw_cmd <= 8'h00;
		cnt = 0;
		repeat (10) begin
			settle(1);
			cnt += int'(stop_req === 1'b1);
		end
		`CHK(cnt, 1)
		`CHK(drive_output_en, 1'b0)
		$display("test enable done");
	endtask : t_enable

	task automatic t_pid();
		do_reset();
		codes = '{8'h2E, 8'h30, 8'h31, 8'h32};
		for (int i = 0; i < 4; i++) begin
			wr(`TFC_REG_IN_SEL0 + 4'h3, {8'h00, codes[i]});
			sw(8'h08);
			`CHK({pid_char_alt, pid_ramp_bypass, pid_integ_hold, ~pid_active}, 4'b0001 << i)
			sw(8'h00);
			`CHK({pid_char_alt, pid_ramp_bypass, pid_integ_hold, ~pid_active}, 4'b0000)
		end
		for (int i = 0; i < 3; i++) begin
			wr(`TFC_REG_IN_SEL0 + 4'h3, 16'h0035 + 16'(i));
			sw(8'h08);
			`CHK(offset_add_en, 3'b001 << i)
			sw(8'h00);
		end
		wr(`TFC_REG_IN_SEL0 + 4'h3, 16'h002F);
		sw_cmd <= 8'h08;
		cnt = 0;
		repeat (8) begin
			settle(1);
			cnt += int'(pid_integ_clear === 1'b1);
		end
		`CHK(cnt, 1)
		$display("test pid done");
	endtask : t_pid

	task automatic t_lockout();
		do_reset();
		wr(`TFC_REG_IN_SEL0 + 4'h2, 16'h003C);
		wr(`TFC_REG_CTRL, 16'h0007);
		rd(`TFC_REG_CTRL);
		`CHK(rd_d, 16'h0001)
		wr(`TFC_REG_FREQ_MON, 16'h1234);
		rd(`TFC_REG_FREQ_MON);
		`CHK(rd_d, 16'h1234)
		sw(8'h04);
		wr(`TFC_REG_CTRL, 16'h0003);
		rd(`TFC_REG_CTRL);
		`CHK(rd_d, 16'h0003)
		$display("test lockout done");
	endtask : t_lockout

	task automatic t_hold();
		do_reset();
		wr(`TFC_REG_IN_SEL0 + 4'h4, 16'h003D);
		analog_freq_cmd <= 16'h1234;
		sw(8'h10);
		@(posedge ref_clk);
		analog_freq_cmd <= 16'h2222;
		settle(3);
		`CHK(freq_ref, 16'h2222)
		`CHK(hold_conflict_error, 1'b0)
		settle(25);
		@(posedge ref_clk);
		analog_freq_cmd <= 16'h5678;
		settle(3);
		`CHK(freq_ref, 16'h2222)
		wr(`TFC_REG_IN_SEL0 + 4'h5, 16'h0012);
		settle(3);
		`CHK(hold_conflict_error, 1'b1)
		@(posedge ref_clk);
		reset_n <= 1'b0;
		settle(2);
		`CHK(freq_ref, 16'h0000)
		@(posedge ref_clk);
		reset_n <= 1'b1;
		settle(3);
		`CHK(freq_ref, 16'h5678)
		$display("test hold done");
	endtask : t_hold

	task automatic t_brake_comm();
		do_reset();
		wr(`TFC_REG_IN_SEL0 + 4'h7, 16'h0041);
		wr(`TFC_REG_OUT_SEL0 + 4'h2, 16'h0070);
		sw(8'h80);
		`CHK(dc_brake, 1'b1)
		`CHK(out_term[2], 1'b1)
		@(posedge ref_clk);
		jog_req <= 1'b1;
		settle(3);
		`CHK(dc_brake, 1'b0)
		@(posedge ref_clk);
		jog_req <= 1'b0;
		wr(`TFC_REG_IN_SEL0 + 4'h6, 16'h002D);
		wr(`TFC_REG_IN_SEL0, 16'h0028);
		comm_term_in <= 8'h41;
		sw(8'h40);
		`CHK(external_overheat_alarm, 1'b1)
		`CHK(out_term[2], 1'b0)
		@(posedge ref_clk);
		comm_term_in <= 8'h40;
		settle(3);
		`CHK(external_overheat_alarm, 1'b0)
		$display("test brake_comm done");
	endtask : t_brake_comm

	task automatic print_verdict();
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		#(50 * 20000);
		num_errors++;
		print_verdict();
	end

	initial begin
		reset_n = 1'b0; jog_req = 1'b0; keypad_reset = 1'b0; fault_detect = 1'b0;
		reg_wr = 1'b0; reg_rd = 1'b0; run_cmd = 1'b0; sw_cmd = 8'h00;
		comm_term_in = 8'h00; analog_freq_cmd = 16'h0000; reg_wdata = 16'h0000;
		reg_addr = 4'h0; num_errors = 0; n_tests = 0;
		t_regs();
		t_overheat();
		t_fault();
		t_enable();
		t_pid();
		t_lockout();
		t_hold();
		t_brake_comm();
		print_verdict();
	end
endmodule : tb_top
